// File: common/pan_pkg.sv
// Package for the auto-negotiation advertisement block
package pan_pkg;
    localparam logic [11:0] ADVERT_OFFSET = 12'h000;
    localparam logic [11:0] CONTROL_OFFSET = 12'h004;
    localparam logic [11:0] STATUS_OFFSET = 12'h008;
    localparam int NEXT_PAGE_BIT = 15;
    localparam int FAULT_BIT = 13;
    localparam int A100F_BIT = 8;
    localparam int A100H_BIT = 7;
    localparam int A10F_BIT = 6;
    localparam int A10H_BIT = 5;
    localparam int RESTART_BIT = 0;
    localparam logic [3:0] ABILITY_RESET = 4'hF;
    localparam logic [15:0] ADVERT_WMASK = 16'h21E0;
    localparam logic [4:0] SELECTOR_DEFAULT = 5'h01;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
    typedef struct packed {
        logic next_page_capable;
        logic remote_fault_advert;
        logic [3:0] ability;
    } pan_advert_type;
endpackage

// File: hdl/pan_field.sv
// One software-writable advertisement bit with its reset value
`timescale 1ns/10ps
`default_nettype none
module pan_field #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic wr_bit,
    output logic q_r
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= RESET_VAL;
        end else if (wr_en) begin
            q_r <= wr_bit;
        end
    end
endmodule
`default_nettype wire

// File: hdl/pan_advert.sv
// Auto-negotiation advertisement register with APB access
// Contract
// - Bit 15 is read-only next-page capability, reset zero.
// - Bit 13 read/write remote fault advertisement, reset zero.
// - Bits 14 and 12:9 reserved, read zero, writes ignored.
// - Bit 8 read/write 100 full-duplex ability, reset one.
// - Bit 7 read/write 100 half-duplex ability, reset one.
// - Bit 6 read/write 10 full-duplex ability, reset one.
// - Bit 5 read/write 10 half-duplex ability, reset one.
// - Cleared ability stops being advertised after negotiation restart.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module pan_advert #(
    parameter logic NEXT_PAGE_CAP = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output pan_pkg::pan_advert_type adv_out_r,
    output logic restart_negotiation_r
);
    logic wr_acc;
    logic rd_acc;
    logic adv_wr;
    logic ctl_wr;
    logic [3:0] ability_r;
    logic remote_fault_r;
    logic [15:0] advert_word;
    logic [31:0] rdata_nxt;
    logic err_nxt;
    logic pending_r;
    logic addr_hit;

    // Writes land only at the edge where the answer is seen, never twice
    assign wr_acc = psel && penable && pwrite && pready;
    assign rd_acc = psel && penable && !pwrite;
    assign adv_wr = wr_acc && paddr == pan_pkg::ADVERT_OFFSET;
    assign ctl_wr = wr_acc && paddr == pan_pkg::CONTROL_OFFSET;
    assign addr_hit = paddr == pan_pkg::ADVERT_OFFSET ||
        paddr == pan_pkg::CONTROL_OFFSET || paddr == pan_pkg::STATUS_OFFSET;

    // Ability bits, reset to advertise every mode
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ab
            pan_field #(.RESET_VAL(pan_pkg::ABILITY_RESET[g])) u_ab (
                .clk(clk),
                .rst_n(rst_n),
                .wr_en(adv_wr),
                .wr_bit(pwdata[pan_pkg::A10H_BIT + g]),
                .q_r(ability_r[g])
            );
        end
    endgenerate

    pan_field #(.RESET_VAL(1'b0)) u_rf (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(adv_wr),
        .wr_bit(pwdata[pan_pkg::FAULT_BIT]),
        .q_r(remote_fault_r)
    );

    // Reserved and read-only bits never take write data
    always_comb begin
        advert_word = 16'h0000;
        advert_word[pan_pkg::NEXT_PAGE_BIT] = NEXT_PAGE_CAP;
        advert_word[pan_pkg::FAULT_BIT] = remote_fault_r;
        advert_word[pan_pkg::A10H_BIT +: 4] = ability_r;
        advert_word[4:0] = pan_pkg::SELECTOR_DEFAULT;
    end

    // Restart bit self-clears once the new advertisement is latched
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            restart_negotiation_r <= 1'b0;
        end else if (ctl_wr) begin
            restart_negotiation_r <= pwdata[pan_pkg::RESTART_BIT];
        end else begin
            restart_negotiation_r <= 1'b0;
        end
    end

    // Link-facing image only changes on restart, so edits stay atomic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adv_out_r <= '{1'b0, 1'b0, pan_pkg::ABILITY_RESET};
        end else if (restart_negotiation_r) begin
            adv_out_r <= '{NEXT_PAGE_CAP, remote_fault_r, ability_r};
        end
    end

    // Edits not yet advertised
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_r <= 1'b0;
        end else if (adv_wr) begin
            pending_r <= 1'b1;
        end else if (restart_negotiation_r) begin
            pending_r <= 1'b0;
        end
    end

    always_comb begin
        rdata_nxt = pan_pkg::RDATA_ZERO;
        err_nxt = 1'b0;
        if (paddr == pan_pkg::ADVERT_OFFSET) begin
            rdata_nxt[15:0] = advert_word;
        end else if (paddr == pan_pkg::CONTROL_OFFSET) begin
            rdata_nxt[pan_pkg::RESTART_BIT] = restart_negotiation_r;
        end else if (paddr == pan_pkg::STATUS_OFFSET) begin
            rdata_nxt[0] = pending_r;
        end else begin
            err_nxt = 1'b1;
        end
    end

    // Registered answer: one wait state per access
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= pan_pkg::RDATA_ZERO;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            prdata <= rd_acc ? rdata_nxt : pan_pkg::RDATA_ZERO;
            pslverr <= err_nxt;
        end else begin
            pready <= 1'b0;
            prdata <= pan_pkg::RDATA_ZERO;
            pslverr <= 1'b0;
        end
    end

    a_np_readonly: assert property (@(posedge clk) disable iff (!rst_n)
        advert_word[pan_pkg::NEXT_PAGE_BIT] == NEXT_PAGE_CAP)
        else $error("next page bit changed");
    a_rf_write: assert property (@(posedge clk) disable iff (!rst_n)
        adv_wr && pready |=> remote_fault_r == $past(pwdata[pan_pkg::FAULT_BIT]))
        else $error("remote fault write lost");
    a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
        advert_word[14] == 1'b0 && advert_word[12:9] == 4'h0)
        else $error("reserved bits not zero");
    a_a100f_write: assert property (@(posedge clk) disable iff (!rst_n)
        adv_wr && pready |=> ability_r[3] == $past(pwdata[8]))
        else $error("100 full write lost");
    a_a100h_write: assert property (@(posedge clk) disable iff (!rst_n)
        adv_wr && pready |=> ability_r[2] == $past(pwdata[7]))
        else $error("100 half write lost");
    a_a10f_write: assert property (@(posedge clk) disable iff (!rst_n)
        adv_wr && pready |=> ability_r[1] == $past(pwdata[6]))
        else $error("10 full write lost");
    a_a10h_write: assert property (@(posedge clk) disable iff (!rst_n)
        adv_wr && pready |=> ability_r[0] == $past(pwdata[5]))
        else $error("10 half write lost");
    sequence s_restart;
        ctl_wr && pready && pwdata[0] ##1 restart_negotiation_r;
    endsequence
    a_restart_advert: assert property (@(posedge clk) disable iff (!rst_n)
        s_restart |=> adv_out_r.ability == $past(ability_r))
        else $error("advertisement not updated on restart");
    a_restart_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        restart_negotiation_r && !ctl_wr |=> !restart_negotiation_r)
        else $error("restart not one cycle");

    // Answer timing: one wait state, then a one-cycle answer
    sequence s_wait_cycle;
        psel && penable && !pready;
    endsequence

    sequence s_adv_read;
        pready && !pwrite && paddr == pan_pkg::ADVERT_OFFSET;
    endsequence

    a_ready_wait: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_wait_cycle |=> pready)
        else $error("access not answered after one wait state");

    a_ready_pulse: assert property (
        @(posedge clk) disable iff (!rst_n)
        pready |=> !pready)
        else $error("ready held longer than one cycle");

    a_ready_idle: assert property (
        @(posedge clk) disable iff (!rst_n)
        !(psel && penable) |=> !pready)
        else $error("ready without an access");

    a_err_ready: assert property (
        @(posedge clk) disable iff (!rst_n)
        pslverr |-> pready)
        else $error("error flag outside the answer");

    a_rdata_idle: assert property (
        @(posedge clk) disable iff (!rst_n)
        !pready |-> prdata == pan_pkg::RDATA_ZERO)
        else $error("read data outside the answer");

    a_wdata_quiet: assert property (
        @(posedge clk) disable iff (!rst_n)
        pready && pwrite |-> prdata == pan_pkg::RDATA_ZERO)
        else $error("read data driven on a write");

    a_err_unmapped: assert property (
        @(posedge clk) disable iff (!rst_n)
        pready && !addr_hit |-> pslverr)
        else $error("unmapped access not refused");

    a_err_mapped: assert property (
        @(posedge clk) disable iff (!rst_n)
        pready && addr_hit |-> !pslverr)
        else $error("mapped access refused");

    // Read path of the advertisement word
    a_np_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_adv_read |-> prdata[pan_pkg::NEXT_PAGE_BIT] == NEXT_PAGE_CAP)
        else $error("next page bit misread");

    a_reserved_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_adv_read |-> prdata[14] == 1'b0 && prdata[12:9] == 4'h0)
        else $error("reserved bits read nonzero");

    a_rf_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_adv_read |-> prdata[pan_pkg::FAULT_BIT] == remote_fault_r)
        else $error("remote fault bit misread");

    a_ability_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_adv_read |-> prdata[pan_pkg::A10H_BIT +: 4] == ability_r)
        else $error("ability bits misread");

    a_upper_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_adv_read |-> prdata[31:16] == 16'h0000)
        else $error("upper half of advertisement read nonzero");

    a_selector_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_adv_read |-> prdata[4:0] == pan_pkg::SELECTOR_DEFAULT)
        else $error("selector field misread");

    // Reset values, checked without the reset disable
    a_reset_fields: assert property (
        @(posedge clk)
        !rst_n |=> ability_r == pan_pkg::ABILITY_RESET && !remote_fault_r)
        else $error("field reset values wrong");

    a_reset_advert: assert property (
        @(posedge clk)
        !rst_n |=> adv_out_r.ability == pan_pkg::ABILITY_RESET &&
            !adv_out_r.remote_fault_advert)
        else $error("advertised image not reset");

    a_reset_answer: assert property (
        @(posedge clk)
        !rst_n |=> !pready && !pslverr && !restart_negotiation_r)
        else $error("bus answer or restart active in reset");

    // Fields change only through an accepted write; restart only through a control write, the advertised image only on restart
    a_field_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        !adv_wr |=> $stable(ability_r) && $stable(remote_fault_r))
        else $error("field changed without a write");

    a_restart_cause: assert property (
        @(posedge clk) disable iff (!rst_n)
        !ctl_wr |=> !restart_negotiation_r)
        else $error("restart without a control write");

    a_restart_take: assert property (
        @(posedge clk) disable iff (!rst_n)
        ctl_wr && pwdata[pan_pkg::RESTART_BIT] |=> restart_negotiation_r)
        else $error("restart request lost");

    a_advert_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        !restart_negotiation_r |=> $stable(adv_out_r))
        else $error("advertisement changed without restart");

    a_restart_fault: assert property (
        @(posedge clk) disable iff (!rst_n)
        restart_negotiation_r |=> adv_out_r.remote_fault_advert ==
            $past(remote_fault_r))
        else $error("remote fault not advertised on restart");

    a_restart_np: assert property (
        @(posedge clk) disable iff (!rst_n)
        restart_negotiation_r |=>
            adv_out_r.next_page_capable == NEXT_PAGE_CAP)
        else $error("next page flag not advertised on restart");

    // Status and control read-back
    a_pending_set: assert property (
        @(posedge clk) disable iff (!rst_n)
        adv_wr |=> pending_r)
        else $error("pending flag not set by an edit");

    a_pending_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        restart_negotiation_r && !adv_wr |=> !pending_r)
        else $error("pending flag not cleared by restart");

    a_status_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        pready && !pwrite && paddr == pan_pkg::STATUS_OFFSET
        |-> prdata[0] == $past(pending_r))
        else $error("status bit misread");

    a_ctl_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        pready && !pwrite && paddr == pan_pkg::CONTROL_OFFSET
        |-> prdata[pan_pkg::RESTART_BIT] == $past(restart_negotiation_r))
        else $error("control bit misread");
endmodule
`default_nettype wire

// File: bench/pan_link_partner.sv
// Behavioural link partner that latches the advertised word
`timescale 1ns/10ps
`default_nettype none
module pan_link_partner (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire pan_pkg::pan_advert_type adv,
    output pan_pkg::pan_advert_type seen_r
);
    logic pend_r;
    // Sample one cycle late, after the new word has landed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_r <= 1'b0;
            seen_r <= '0;
        end else begin
            pend_r <= restart;
            if (pend_r) begin
                seen_r <= adv;
            end
        end
    end
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the advertisement register
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, rst_pls, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    pan_pkg::pan_advert_type adv, seen;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    pan_advert i_pan_advert (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .adv_out_r(adv), .restart_negotiation_r(rst_pls));
    pan_link_partner i_pan_link_partner (.clk(clk), .rst_n(rst_n),
        .restart(rst_pls), .adv(adv), .seen_r(seen));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Restart, then allow pulse, update and partner capture
    task automatic restart();
        apb(1'b1, pan_pkg::CONTROL_OFFSET, 32'h0000_0001);
        @(posedge clk);
        chk("restart", {31'h0, rst_pls}, 32'h1);
        @(posedge clk);
        chk("restart", {31'h0, rst_pls}, 32'h0);
        repeat (2) @(posedge clk);
    endtask
    task automatic t_reset();
        chk("adv", {26'h0, adv}, 32'h0000_000F);
        apb(1'b0, pan_pkg::ADVERT_OFFSET, 32'h0);
        chk("advert", rd, 32'h0000_01E1);
    endtask
    task automatic t_mask();
        apb(1'b1, pan_pkg::ADVERT_OFFSET, 32'hFFFF_FFFF);
        apb(1'b0, pan_pkg::ADVERT_OFFSET, 32'h0);
        chk("advert", rd, 32'h0000_21E1);
        chk("adv", {26'h0, adv}, 32'h0000_000F);
        apb(1'b0, pan_pkg::STATUS_OFFSET, 32'h0);
        chk("status", rd, 32'h0000_0001);
    endtask
    // Each ability alone, then the fault flag alone, must reach the partner
    task automatic t_each();
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, pan_pkg::ADVERT_OFFSET,
                i < 4 ? 32'h20 << i : 32'h0000_2000);
            restart();
            chk("adv", {26'h0, adv}, (32'h1 << i) & 32'h1F);
            chk("partner", {26'h0, seen}, (32'h1 << i) & 32'h1F);
        end
        apb(1'b0, pan_pkg::STATUS_OFFSET, 32'h0);
        chk("status", rd, 32'h0);
        apb(1'b0, pan_pkg::CONTROL_OFFSET, 32'h0);
        chk("control", rd, 32'h0);
    endtask
    task automatic t_unmapped();
        apb(1'b0, 12'hFFC, 32'h0);
        chk("err", {31'h0, err}, 32'h1);
        chk("rdata", rd, 32'h0);
        apb(1'b1, 12'hFFC, 32'h0);
        chk("err", {31'h0, err}, 32'h1);
    endtask
    // Reset in mid-run must bring back the reset advertisement
    task automatic t_midreset();
        apb(1'b1, pan_pkg::ADVERT_OFFSET, 32'h0000_2000);
        restart();
        chk("adv", {26'h0, adv}, 32'h0000_0010);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk("adv", {26'h0, adv}, 32'h0000_000F);
        rst_n <= 1'b1;
        apb(1'b0, pan_pkg::ADVERT_OFFSET, 32'h0);
        chk("advert", rd, 32'h0000_01E1);
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Hang guard, far above the roughly 115 cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            end_sim();
        end
    end
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_mask();
        t_each();
        t_unmapped();
        t_midreset();
        end_sim();
    end
endmodule
`default_nettype wire
